// >>> clock_dist_pkg.sv
// Constants, field layouts and carrier types for the clock distribution register bank.
package clock_dist_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SERIAL_PORT_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_DIV_TWO_CONTROL = 8'h4f;
  localparam logic [7:0] ADDR_DIV_THREE_CYCLES = 8'h50;
  localparam logic [7:0] ADDR_DIV_THREE_CONTROL = 8'h51;
  localparam logic [7:0] ADDR_DIV_FOUR_CYCLES = 8'h52;
  localparam logic [7:0] ADDR_DIV_FOUR_CONTROL = 8'h53;
  localparam logic [7:0] ADDR_MULTIPURPOSE_PIN_SYNC = 8'h58;
  localparam logic [7:0] ADDR_UPDATE_STROBE = 8'h5a;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SERIAL_PORT_CONFIG = 8'h10;
  localparam logic [7:0] RST_DIV_TWO_CONTROL = 8'h00;
  localparam logic [7:0] RST_DIV_THREE_CYCLES = 8'h00;
  localparam logic [7:0] RST_DIV_THREE_CONTROL = 8'h00;
  localparam logic [7:0] RST_DIV_FOUR_CYCLES = 8'h11;
  localparam logic [7:0] RST_DIV_FOUR_CONTROL = 8'h00;
  localparam logic [7:0] RST_MULTIPURPOSE_PIN_SYNC = 8'h00;
  localparam logic [7:0] RST_UPDATE_STROBE = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CFG_BIDIR_BIT = 7;
  localparam int unsigned CFG_LSB_FIRST_BIT = 6;
  localparam int unsigned CFG_SOFT_RESET_BIT = 5;
  localparam int unsigned CFG_LONG_INSTR_BIT = 4;
  localparam logic [7:0] CFG_WRITABLE_MASK = 8'hf0;
  localparam int unsigned UPDATE_BIT = 0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [3:0] low_cycles;
    logic [3:0] high_cycles;
  } div_cycles_t;

  typedef struct packed {
    logic bypass;
    logic no_sync;
    logic force_sync;
    logic start_high;
    logic [3:0] phase_offset;
  } div_ctrl_t;

  typedef struct packed {
    logic unused;
    logic [1:0] pin_function;
    logic pd_sync;
    logic pd_all_ref;
    logic sync_reg;
    logic sync_select;
    logic sync_enable;
  } func_sync_t;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;

endpackage

// >>> buffered_reg.sv
// One buffered register: host-visible shadow plus active copy loaded on update.
`timescale 1ns/1ps
`default_nettype none
module buffered_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic soft_rst_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic update_in,
  output logic [7:0] shadow_out,
  output logic [7:0] active_out
);

  logic [7:0] shadow_q;
  logic [7:0] active_q;

  // Soft reset is a level: while held, both copies sit at the default.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shadow_q <= RESET_VAL;
    end else if (soft_rst_in) begin
      shadow_q <= RESET_VAL;
    end else if (wr_in) begin
      shadow_q <= wdata_in;
    end
  end

  // A write landing with the update pulse is carried straight to the active copy.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      active_q <= RESET_VAL;
    end else if (soft_rst_in) begin
      active_q <= RESET_VAL;
    end else if (update_in) begin
      active_q <= wr_in ? wdata_in : shadow_q;
    end
  end

  assign shadow_out = shadow_q;
  assign active_out = active_q;

endmodule // buffered_reg
`default_nettype wire

// >>> serial_pin_steer.sv
// Steers serial read data onto the dedicated output pin or the shared data pin.
`timescale 1ns/1ps
`default_nettype none
module serial_pin_steer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic bidir_in,
  input wire logic read_phase_in,
  input wire logic read_bit_in,
  output clock_dist_pkg::pin_drive_t serial_out_pin_out,
  output clock_dist_pkg::pin_drive_t data_pin_out
);

  clock_dist_pkg::pin_drive_t sop_q;
  clock_dist_pkg::pin_drive_t sdp_q;

  // In bidirectional mode the dedicated output floats and reads use the shared pin.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sop_q <= '{o: 1'b0, oe: 1'b1};
      sdp_q <= '{o: 1'b0, oe: 1'b0};
    end else if (bidir_in) begin
      sop_q <= '{o: 1'b0, oe: 1'b0};
      sdp_q <= '{o: read_phase_in & read_bit_in, oe: read_phase_in};
    end else begin
      sop_q <= '{o: read_phase_in & read_bit_in, oe: 1'b1};
      sdp_q <= '{o: 1'b0, oe: 1'b0};
    end
  end

  assign serial_out_pin_out = sop_q;
  assign data_pin_out = sdp_q;

endmodule // serial_pin_steer
`default_nettype wire

// >>> clock_dist_config_regs.sv
// Control register bank of the clock distribution device behind its serial port.
`timescale 1ns/1ps
`default_nettype none
module clock_dist_config_regs (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire clock_dist_pkg::reg_req_t req_in,
  input wire logic read_phase_in,
  input wire logic read_bit_in,
  output logic [7:0] rdata_out,
  output logic rdata_valid_out,
  output logic long_instr_out,
  output logic lsb_first_out,
  output logic addr_increment_out,
  output logic soft_reset_out,
  output logic bidir_out,
  output clock_dist_pkg::pin_drive_t serial_out_pin_out,
  output clock_dist_pkg::pin_drive_t data_pin_out,
  output clock_dist_pkg::div_ctrl_t div_two_ctrl_out,
  output clock_dist_pkg::div_cycles_t div_three_cycles_out,
  output clock_dist_pkg::div_ctrl_t div_three_ctrl_out,
  output clock_dist_pkg::div_cycles_t div_four_cycles_out,
  output clock_dist_pkg::div_ctrl_t div_four_ctrl_out,
  output clock_dist_pkg::func_sync_t func_sync_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int unsigned NUM_BUF = 6;

  logic [7:0] config_q;
  logic update_q;
  logic update_d;
  logic soft_rst;
  logic [7:0] rdata_q;
  logic rdata_valid_q;
  logic [7:0] rdata_d;
  logic [NUM_BUF-1:0] buf_wr;
  logic [7:0] buf_shadow [NUM_BUF];
  logic [7:0] buf_active [NUM_BUF];

  localparam logic [7:0] BUF_ADDR [NUM_BUF] = '{
    clock_dist_pkg::ADDR_DIV_TWO_CONTROL,
    clock_dist_pkg::ADDR_DIV_THREE_CYCLES,
    clock_dist_pkg::ADDR_DIV_THREE_CONTROL,
    clock_dist_pkg::ADDR_DIV_FOUR_CYCLES,
    clock_dist_pkg::ADDR_DIV_FOUR_CONTROL,
    clock_dist_pkg::ADDR_MULTIPURPOSE_PIN_SYNC
  };

  localparam logic [7:0] BUF_RESET [NUM_BUF] = '{
    clock_dist_pkg::RST_DIV_TWO_CONTROL,
    clock_dist_pkg::RST_DIV_THREE_CYCLES,
    clock_dist_pkg::RST_DIV_THREE_CONTROL,
    clock_dist_pkg::RST_DIV_FOUR_CYCLES,
    clock_dist_pkg::RST_DIV_FOUR_CONTROL,
    clock_dist_pkg::RST_MULTIPURPOSE_PIN_SYNC
  };

  // ----------------------------------------------------------------
  // Serial port configuration register
  // ----------------------------------------------------------------
  // Only the hardware reset touches this register; soft reset leaves it alone so
  // the host keeps its framing while the rest of the chip is held at defaults.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      config_q <= clock_dist_pkg::RST_SERIAL_PORT_CONFIG;
    end else if (req_in.wr && req_in.addr == clock_dist_pkg::ADDR_SERIAL_PORT_CONFIG) begin
      config_q <= req_in.wdata & clock_dist_pkg::CFG_WRITABLE_MASK;
    end
  end

  assign soft_rst = config_q[clock_dist_pkg::CFG_SOFT_RESET_BIT];

  // ----------------------------------------------------------------
  // Update strobe
  // ----------------------------------------------------------------
  always_comb begin
    update_d = 1'b0;
    if (!soft_rst && req_in.wr && req_in.addr == clock_dist_pkg::ADDR_UPDATE_STROBE) begin
      update_d = req_in.wdata[clock_dist_pkg::UPDATE_BIT];
    end
  end

  // The bit lives one cycle and clears itself, so reads rarely see it set.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      update_q <= 1'b0;
    end else begin
      update_q <= update_d;
    end
  end

  // ----------------------------------------------------------------
  // Buffered registers
  // ----------------------------------------------------------------
  // The pulse comes one cycle after the strobe write and copies the shadow; a
  // buffered write landing in that same cycle goes straight to the active copy.
  for (genvar i = 0; i < NUM_BUF; i++) begin : g_buf
    assign buf_wr[i] = req_in.wr && req_in.addr == BUF_ADDR[i];
    buffered_reg #(
      .RESET_VAL(BUF_RESET[i])
    ) u_reg (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .soft_rst_in(soft_rst),
      .wr_in(buf_wr[i]),
      .wdata_in(req_in.wdata),
      .update_in(update_q),
      .shadow_out(buf_shadow[i]),
      .active_out(buf_active[i])
    );
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  // Reads show the shadow copy: what the host wrote, even before an update.
  always_comb begin
    rdata_d = clock_dist_pkg::READ_ZERO;
    unique case (req_in.addr)
      clock_dist_pkg::ADDR_SERIAL_PORT_CONFIG: begin
        rdata_d = config_q;
      end
      clock_dist_pkg::ADDR_DIV_TWO_CONTROL: begin
        rdata_d = buf_shadow[0];
      end
      clock_dist_pkg::ADDR_DIV_THREE_CYCLES: begin
        rdata_d = buf_shadow[1];
      end
      clock_dist_pkg::ADDR_DIV_THREE_CONTROL: begin
        rdata_d = buf_shadow[2];
      end
      clock_dist_pkg::ADDR_DIV_FOUR_CYCLES: begin
        rdata_d = buf_shadow[3];
      end
      clock_dist_pkg::ADDR_DIV_FOUR_CONTROL: begin
        rdata_d = buf_shadow[4];
      end
      clock_dist_pkg::ADDR_MULTIPURPOSE_PIN_SYNC: begin
        rdata_d = buf_shadow[5];
      end
      clock_dist_pkg::ADDR_UPDATE_STROBE: begin
        rdata_d = {7'h00, update_q};
      end
      default: begin
        rdata_d = clock_dist_pkg::READ_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= clock_dist_pkg::READ_ZERO;
    end else if (req_in.rd) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_valid_q <= 1'b0;
    end else begin
      rdata_valid_q <= req_in.rd;
    end
  end

  assign rdata_out = rdata_q;
  assign rdata_valid_out = rdata_valid_q;

  // ----------------------------------------------------------------
  // Serial port controls
  // ----------------------------------------------------------------
  assign long_instr_out = config_q[clock_dist_pkg::CFG_LONG_INSTR_BIT];
  assign lsb_first_out = config_q[clock_dist_pkg::CFG_LSB_FIRST_BIT];
  // LSB-first transfers step addresses upward, MSB-first transfers step down.
  assign addr_increment_out = config_q[clock_dist_pkg::CFG_LSB_FIRST_BIT];
  assign soft_reset_out = soft_rst;
  assign bidir_out = config_q[clock_dist_pkg::CFG_BIDIR_BIT];

  serial_pin_steer u_pins (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .bidir_in(config_q[clock_dist_pkg::CFG_BIDIR_BIT]),
    .read_phase_in(read_phase_in),
    .read_bit_in(read_bit_in),
    .serial_out_pin_out(serial_out_pin_out),
    .data_pin_out(data_pin_out)
  );

  // ----------------------------------------------------------------
  // Active settings
  // ----------------------------------------------------------------
  assign div_two_ctrl_out = clock_dist_pkg::div_ctrl_t'(buf_active[0]);
  assign div_three_cycles_out = clock_dist_pkg::div_cycles_t'(buf_active[1]);
  assign div_three_ctrl_out = clock_dist_pkg::div_ctrl_t'(buf_active[2]);
  assign div_four_cycles_out = clock_dist_pkg::div_cycles_t'(buf_active[3]);
  assign div_four_ctrl_out = clock_dist_pkg::div_ctrl_t'(buf_active[4]);
  assign func_sync_out = clock_dist_pkg::func_sync_t'(buf_active[5]);

endmodule // clock_dist_config_regs
`default_nettype wire

// >>> clock_dist_config_regs_monitor.sv
// Port-level assertions for the clock distribution register bank.
`timescale 1ns/1ps
`default_nettype none
module clock_dist_config_regs_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire clock_dist_pkg::reg_req_t req_in,
  input wire logic read_phase_in,
  input wire logic long_instr_out,
  input wire logic lsb_first_out,
  input wire logic addr_increment_out,
  input wire logic soft_reset_out,
  input wire logic bidir_out,
  input wire clock_dist_pkg::pin_drive_t serial_out_pin_out,
  input wire clock_dist_pkg::pin_drive_t data_pin_out,
  input wire clock_dist_pkg::div_cycles_t div_four_cycles_out
);
  logic cfg_wr;
  logic upd_req;
  logic [3:0] cfg_hi;
  assign cfg_wr = req_in.wr && req_in.addr == 8'h00;
  assign upd_req = req_in.wr && req_in.addr == 8'h5a && req_in.wdata[0];
  assign cfg_hi = req_in.wdata[7:4];
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_sdo_float; serial_out_pin_out.oe == !$past(bidir_out); endproperty
  a_sdo_float: assert property (p_sdo_float)
    else $error("serial out enable wrong");
  property p_data_pin;
    data_pin_out.oe == ($past(bidir_out) && $past(read_phase_in));
  endproperty
  a_data_pin: assert property (p_data_pin)
    else $error("data pin enable wrong");
  property p_soft_sticky; soft_reset_out && !cfg_wr |=> soft_reset_out; endproperty
  a_soft_sticky: assert property (p_soft_sticky)
    else $error("soft reset cleared itself");
  property p_soft_defaults; soft_reset_out |=> div_four_cycles_out == 8'h11; endproperty
  a_soft_defaults: assert property (p_soft_defaults)
    else $error("soft reset left divider set");
  property p_cfg_now;
    cfg_wr |=> {bidir_out, lsb_first_out, soft_reset_out, long_instr_out} == $past(cfg_hi);
  endproperty
  a_cfg_now: assert property (p_cfg_now)
    else $error("config write not immediate");
  property p_addr_dir; addr_increment_out == lsb_first_out; endproperty
  a_addr_dir: assert property (p_addr_dir)
    else $error("address step direction wrong");
  property p_reset_vals;
    $fell(rst_in) |-> long_instr_out && !bidir_out && div_four_cycles_out == 8'h11;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset values wrong");
  property p_active_hold;
    $changed(div_four_cycles_out) |-> $past(soft_reset_out) || $past(upd_req, 2);
  endproperty
  a_active_hold: assert property (p_active_hold)
    else $error("active divider moved without update");
  c_update: cover property (upd_req);
  c_soft_exit: cover property (soft_reset_out ##1 !soft_reset_out);
  c_bidir_read: cover property (data_pin_out.oe);
endmodule // clock_dist_config_regs_monitor

bind clock_dist_config_regs clock_dist_config_regs_monitor clock_dist_config_regs_monitor_inst (
  .clk_in, .rst_in, .req_in, .read_phase_in, .long_instr_out, .lsb_first_out,
  .addr_increment_out, .soft_reset_out, .bidir_out, .serial_out_pin_out,
  .data_pin_out, .div_four_cycles_out
);
`default_nettype wire

// >>> host_bfm.sv
// Behavioural host controller that drives the register port and read bits.
`timescale 1ns/1ps
`default_nettype none
module host_bfm (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rdata_valid_in,
  output clock_dist_pkg::reg_req_t req_out,
  output logic read_phase_out,
  output logic read_bit_out
);
  initial begin
    req_out = '0;
    read_phase_out = 1'b0;
    read_bit_out = 1'b0;
  end
  // Released lines show the inverse of the last value, so no stale copy can pass.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_in);
    req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: req_out.wdata};
    @(negedge clk_in);
    req_out.rd = 1'b0;
    req_out.addr = ~a;
    d = rdata_valid_in ? rdata_in : 8'hxx;
  endtask
  task automatic send_bit(input logic b);
    @(negedge clk_in);
    read_phase_out = 1'b1;
    read_bit_out = b;
  endtask
  task automatic end_read();
    @(negedge clk_in);
    read_phase_out = 1'b0;
    read_bit_out = ~read_bit_out;
  endtask
endmodule // host_bfm
`default_nettype wire

// >>> test_clock_dist_config_regs.sv
// Self-checking bench for the clock distribution register bank.
`timescale 1ns/1ps
`default_nettype none
module test_clock_dist_config_regs;
  logic clk_in;
  logic rst_in;
  clock_dist_pkg::reg_req_t req_in;
  logic read_phase_in, read_bit_in, rdata_valid_out;
  logic [7:0] rdata_out, got;
  logic long_instr_out, lsb_first_out, addr_increment_out, soft_reset_out, bidir_out;
  clock_dist_pkg::pin_drive_t serial_out_pin_out, data_pin_out;
  clock_dist_pkg::div_ctrl_t c2, c3, c4;
  clock_dist_pkg::div_cycles_t y3, y4;
  clock_dist_pkg::func_sync_t fs;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // Row: address, byte written, value after reset, value read back.
  typedef struct { logic [7:0] a, w, r, e; } row_t;
  row_t rows[10] = '{'{8'h4f, 8'ha5, 8'h00, 8'ha5}, '{8'h50, 8'h3c, 8'h00, 8'h3c},
    '{8'h51, 8'hff, 8'h00, 8'hff}, '{8'h52, 8'h35, 8'h11, 8'h35},
    '{8'h53, 8'h81, 8'h00, 8'h81}, '{8'h58, 8'h7e, 8'h00, 8'h7e},
    '{8'h5a, 8'h00, 8'h00, 8'h00}, '{8'h30, 8'h55, 8'h00, 8'h00},
    '{8'h59, 8'h66, 8'h00, 8'h00}, '{8'h00, 8'h4f, 8'h10, 8'h40}};
  clock_dist_config_regs clock_dist_config_regs_inst (
    .clk_in, .rst_in, .req_in, .read_phase_in, .read_bit_in, .rdata_out,
    .rdata_valid_out, .long_instr_out, .lsb_first_out, .addr_increment_out,
    .soft_reset_out, .bidir_out, .serial_out_pin_out, .data_pin_out,
    .div_two_ctrl_out(c2), .div_three_cycles_out(y3), .div_three_ctrl_out(c3),
    .div_four_cycles_out(y4), .div_four_ctrl_out(c4), .func_sync_out(fs));
  host_bfm host_bfm_inst (.clk_in, .rdata_in(rdata_out), .rdata_valid_in(rdata_valid_out),
    .req_out(req_in), .read_phase_out(read_phase_in), .read_bit_out(read_bit_in));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Wide enough for the concatenated checks below, so no part of them is cut off.
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host_bfm_inst.rd(a, got);
    chk(got, e, "register read");
  endtask
  task automatic shift(input logic [7:0] d, input logic lsb);
    logic b;
    chk(lsb_first_out, {7'h00, lsb}, "bit order");
    for (int i = 0; i < 8; i++) begin
      b = lsb ? d[i] : d[7-i];
      host_bfm_inst.send_bit(b);
      @(posedge clk_in);
      #1;
      chk(bidir_out ? data_pin_out : serial_out_pin_out, {6'h0, b, 1'b1}, "pin");
    end
    host_bfm_inst.end_read();
  endtask
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      $display("ERROR %0t timeout", $time);
      stop_test();
    end
  end
  initial begin
    rst_in = 1'b1;
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    foreach (rows[i]) begin
      rdchk(rows[i].a, rows[i].r);
      host_bfm_inst.wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].e);
    end
    chk(long_instr_out, 8'h00, "config");
    chk(y4, 8'h11, "buffered");
    $display("table done");
    host_bfm_inst.wr(8'h5a, 8'h01);
    @(negedge clk_in);
    chk({y3, y4}, 16'h3c35, "cycles");
    chk({c2, c3, c4, fs}, 32'ha5ff817e, "controls");
    rdchk(8'h5a, 8'h00);
    $display("update done");
    host_bfm_inst.wr(8'h00, 8'h30);
    @(negedge clk_in);
    chk({soft_reset_out, y4, c4}, 17'h11100, "soft");
    host_bfm_inst.wr(8'h52, 8'h77);
    host_bfm_inst.wr(8'h5a, 8'h01);
    rdchk(8'h52, 8'h11);
    repeat (5) @(negedge clk_in);
    chk(soft_reset_out, 8'h01, "sticky");
    rdchk(8'h00, 8'h30);
    host_bfm_inst.wr(8'h00, 8'h10);
    host_bfm_inst.wr(8'h52, 8'h77);
    rdchk(8'h52, 8'h77);
    $display("soft reset done");
    host_bfm_inst.wr(8'h00, 8'hc0);
    @(negedge clk_in);
    chk({addr_increment_out, serial_out_pin_out.oe}, 8'h02, "bidir");
    shift(8'hb4, 1'b1);
    host_bfm_inst.wr(8'h00, 8'h10);
    @(negedge clk_in);
    chk({addr_increment_out, data_pin_out.oe}, 8'h00, "unidir");
    shift(8'hb4, 1'b0);
    $display("pins done");
    // Leave the configuration away from its default so the reset check can fail.
    host_bfm_inst.wr(8'h00, 8'he0);
    rst_in = 1'b1;
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    rdchk(8'h00, 8'h10);
    rdchk(8'h52, 8'h11);
    $display("reset done");
    stop_test();
  end
endmodule // test_clock_dist_config_regs
`default_nettype wire
